// ### shared/bsw_pkg.sv
// Purpose: constants and types for the battery switch / watchdog block
// Assumes: 40 MHz clock, Avalon-MM register slave with 32-bit data
// Notes: long times are expressed in microseconds or milliseconds
package bsw_pkg;
   // ----------------------------------------------------------------
   // clock and timing
   // ----------------------------------------------------------------
   localparam int unsigned CLK_HZ = 40_000_000;
   localparam int unsigned DLY_SHORT_MS = 20;
   localparam int unsigned DLY_LONG_MS = 10_000;
   localparam int unsigned IRQ_PULSE_US = 256;
   localparam int unsigned IRQ_PULSE_CYC = IRQ_PULSE_US * (CLK_HZ / 1_000_000);
   localparam int unsigned RST_HOLD_MS = 10_000;
   localparam int unsigned EXIT_HOLD_MS = 800;
   localparam int unsigned RST_PULSE_MS = 250;
   localparam int unsigned WD_UNIT_MS = 1_000;
   localparam int unsigned MS_CYC = CLK_HZ / 1_000;
   localparam int unsigned CNT_W = 40;
   // ----------------------------------------------------------------
   // register offsets (byte addresses, word aligned)
   // ----------------------------------------------------------------
   localparam logic [3:0] OFF_CTRL = 4'h0;
   localparam logic [3:0] OFF_WDOG = 4'h4;
   localparam logic [3:0] OFF_CHG = 4'h8;
   localparam logic [3:0] OFF_STAT = 4'hC;
   // ctrl field positions
   localparam int REQ_LSB = 0;
   localparam int PERMIT_BIT = 2;
   localparam int DLYSEL_BIT = 3;
   localparam int OTG_BIT = 4;
   localparam int BYP_BIT = 5;
   localparam int HIZ_BIT = 6;
   localparam int REGRST_BIT = 7;
   // wdog field positions
   localparam int WDPER_LSB = 0;
   localparam int WDRST_BIT = 2;
   localparam int WDMASK_BIT = 3;
   // reset values
   localparam logic [7:0] CTRL_RST = 8'h00;
   localparam logic [1:0] WDPER_RST = 2'h1;
   localparam logic [7:0] CHARGE_CURRENT_SETTING_RST = 8'h28;
   localparam logic [31:0] UNMAPPED = 32'h0000_0000;
   // mode request codes
   localparam logic [1:0] REQ_NONE = 2'b00;
   localparam logic [1:0] REQ_SHUT = 2'b01;
   localparam logic [1:0] REQ_SHIP = 2'b10;
   localparam logic [1:0] REQ_SRST = 2'b11;

   typedef enum logic [2:0] {
      BSW_NORMAL = 3'b000,
      BSW_DELAY = 3'b001,
      BSW_SHIP_WAIT = 3'b010,
      BSW_SHIP = 3'b011,
      BSW_SHUT = 3'b100,
      BSW_SRST = 3'b101
   } bsw_state_e;

   typedef struct packed {
      logic batSwitchOn;
      logic serialOn;
      logic wakePullUp;
      logic converterHiz;
   } bsw_pwr_s;
endpackage : bsw_pkg

// ### design/bsw_switch_watchdog.sv
// Purpose: battery switch mode sequencer and host watchdog
// Assumes: adapterPresent and wakeButtonN are asynchronous pins
// Notes: registers answer with one wait state
`timescale 1ns/10ps
`default_nettype none
module bsw_switch_watchdog
   import bsw_pkg::*;
#(
   parameter logic [CNT_W-1:0] DLY_LONG_CYC = CNT_W'(DLY_LONG_MS * MS_CYC),
   parameter logic [CNT_W-1:0] DLY_SHORT_CYC = CNT_W'(DLY_SHORT_MS * MS_CYC),
   parameter logic [CNT_W-1:0] RST_HOLD_CYC = CNT_W'(RST_HOLD_MS * MS_CYC),
   parameter logic [CNT_W-1:0] EXIT_HOLD_CYC = CNT_W'(EXIT_HOLD_MS * MS_CYC),
   parameter logic [CNT_W-1:0] RST_PULSE_CYC = CNT_W'(RST_PULSE_MS * MS_CYC),
   parameter logic [CNT_W-1:0] WD_UNIT_CYC = CNT_W'(WD_UNIT_MS * MS_CYC)
) (
   input wire logic clk, // 40 MHz clock
   input wire logic rst_n, // asynchronous reset, active low
   input wire logic [3:0] address, // byte address
   input wire logic read, // avalon read
   input wire logic write, // avalon write
   input wire logic [31:0] writedata, // avalon write data
   input wire logic [3:0] byteenable, // avalon byte enables
   output logic [31:0] readdata, // avalon read data
   output logic waitrequest, // avalon wait
   input wire logic adapterPresent, // adapter above undervoltage level
   input wire logic wakeButtonN, // wake button, active low
   output logic batterySwitch, // battery switch closed when high
   output logic serialEnable, // serial interface enabled
   output logic wakePullUp, // button pull-up enabled
   output logic converterHiz, // converter high impedance
   output logic hostMode, // host mode when high
   output logic safetyTimerShort, // default-mode safety timers active
   output logic chargerOff, // charger fully powered down
   output logic irqN // interrupt pulse, active low
);
   // ----------------------------------------------------------------
   // pin synchronisers
   // ----------------------------------------------------------------
   logic [1:0] adSync;
   logic [1:0] btSync;
   logic adp;
   logic btnLow;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         adSync <= 2'b00;
         btSync <= 2'b11;
      end else begin
         adSync <= {adSync[0], adapterPresent};
         btSync <= {btSync[0], wakeButtonN};
      end
   end
   assign adp = adSync[1];
   assign btnLow = !btSync[1];

   // ----------------------------------------------------------------
   // registers and bus
   // ----------------------------------------------------------------
   logic [1:0] modeReq;
   logic permit;
   logic dlySel;
   logic otgEn;
   logic bypEn;
   logic hizReg;
   logic [1:0] wdPeriod;
   logic wdMask;
   logic [7:0] chargeCurrent;
   logic wdStatus;
   logic wdFlag;
   logic ack;
   logic wrStb;
   logic rdStb;
   logic regDefault; // return ctrl, wdog and charge registers and host mode to power-on values
   logic wdExpire;
   logic wdRestart;
   logic shutReject;
   logic srstReject;
   logic clrAccessory;
   logic srstDone;
   bsw_state_e state;
   bsw_state_e next_state;

   // writes land at the edge that ends the wait; reads load one edge
   // early so that readdata already stands when the master takes it
   assign wrStb = write && ack;
   assign rdStb = read && !ack;
   assign ack = !waitrequest;

   // one wait state: waitrequest drops for the second edge of a request
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         waitrequest <= 1'b1;
      end else begin
         waitrequest <= !((read || write) && waitrequest);
      end
   end

   // ctrl register, hardware overrides win over software writes
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         {hizReg, bypEn, otgEn, dlySel, permit, modeReq} <= CTRL_RST[6:0];
      end else if (regDefault) begin
         {hizReg, bypEn, otgEn, dlySel, permit, modeReq} <= CTRL_RST[6:0];
      end else begin
         if (wrStb && address == OFF_CTRL && byteenable[0]) begin
            modeReq <= writedata[REQ_LSB+:2];
            permit <= writedata[PERMIT_BIT];
            dlySel <= writedata[DLYSEL_BIT];
            otgEn <= writedata[OTG_BIT];
            bypEn <= writedata[BYP_BIT];
            hizReg <= writedata[HIZ_BIT];
         end
         // a finished reset drops its code, else it would rerun forever
         if (shutReject || srstReject || srstDone) begin
            modeReq <= REQ_NONE;
         end
         if (clrAccessory) begin
            otgEn <= 1'b0;
            bypEn <= 1'b0;
         end
         if (wdExpire) begin
            hizReg <= 1'b0;
         end
      end
   end

   // watchdog and charge registers
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wdPeriod <= WDPER_RST;
         wdMask <= 1'b0;
         chargeCurrent <= CHARGE_CURRENT_SETTING_RST;
      end else if (regDefault) begin
         wdPeriod <= WDPER_RST;
         wdMask <= 1'b0;
         chargeCurrent <= CHARGE_CURRENT_SETTING_RST;
      end else if (wdExpire) begin
         chargeCurrent <= {1'b0, chargeCurrent[7:1]};
      end else if (wrStb && byteenable[0]) begin
         if (address == OFF_WDOG) begin
            wdPeriod <= writedata[WDPER_LSB+:2];
            wdMask <= writedata[WDMASK_BIT];
         end
         if (address == OFF_CHG) begin
            chargeCurrent <= writedata[7:0];
         end
      end
   end

   assign wdRestart = wrStb && address == OFF_WDOG && byteenable[0]
      && writedata[WDRST_BIT];

   // read mux; flag clears on read, set wins
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         readdata <= UNMAPPED;
      end else if (rdStb) begin
         case (address)
            OFF_CTRL: readdata <= {25'h0, hizReg, bypEn, otgEn, dlySel,
               permit, modeReq};
            OFF_WDOG: readdata <= {28'h0, wdMask, 1'b0, wdPeriod};
            OFF_CHG: readdata <= {24'h0, chargeCurrent};
            OFF_STAT: readdata <= {25'h0, state, 2'b00, wdFlag, wdStatus};
            default: readdata <= UNMAPPED;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // mode sequencer
   // ----------------------------------------------------------------
   logic [CNT_W-1:0] dlyCnt;
   logic [CNT_W-1:0] btnCnt;
   logic [1:0] pending;
   logic dlyDone;
   logic btnReset;
   logic btnExit;
   logic resetHoldDone;

   assign shutReject = (modeReq == REQ_SHUT) && adp;
   assign srstReject = (modeReq == REQ_SRST) && adp && !permit;
   assign srstDone = state == BSW_SRST && next_state == BSW_NORMAL;
   assign dlyDone = (dlyCnt == '0);
   assign btnReset = (btnCnt == RST_HOLD_CYC) && (permit || !adp)
      && state != BSW_SHUT && state != BSW_SHIP;
   assign btnExit = (btnCnt == EXIT_HOLD_CYC) && state == BSW_SHIP;
   assign clrAccessory = (state == BSW_DELAY && dlyDone
      && pending != REQ_SHIP) || btnReset;

   // button hold counter, saturates one past the reset hold
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         btnCnt <= '0;
      end else if (!btnLow || state == BSW_SHUT) begin
         btnCnt <= '0;
      end else if (btnCnt <= RST_HOLD_CYC) begin
         btnCnt <= btnCnt + CNT_W'(1);
      end
   end

   // next-state decode
   always_comb begin
      next_state = state;
      case (state)
         BSW_NORMAL: begin
            if (btnReset) begin
               next_state = BSW_SRST; // immediate
            end else if (modeReq != REQ_NONE && !shutReject
               && !srstReject) begin
               next_state = BSW_DELAY;
            end
         end
         BSW_DELAY: begin
            if (modeReq == REQ_NONE) begin
               next_state = BSW_NORMAL;
            end else if (btnReset) begin
               next_state = BSW_SRST;
            end else if (dlyDone) begin
               case (pending)
                  REQ_SHUT: next_state = adp ? BSW_NORMAL : BSW_SHUT;
                  REQ_SHIP: next_state = adp ? BSW_SHIP_WAIT : BSW_SHIP;
                  default: next_state = BSW_SRST;
               endcase
            end
         end
         BSW_SHIP_WAIT: begin
            if (modeReq == REQ_NONE) begin
               next_state = BSW_NORMAL;
            end else if (!adp) begin
               next_state = BSW_SHIP;
            end
         end
         BSW_SHIP: begin
            if (btnExit || adp) begin
               next_state = BSW_NORMAL;
            end
         end
         BSW_SHUT: begin
            if (adp) begin
               next_state = BSW_NORMAL;
            end
         end
         BSW_SRST: begin
            if (dlyDone) begin
               next_state = BSW_NORMAL;
            end
         end
         default: next_state = BSW_NORMAL;
      endcase
   end

   // state register and delay counter
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state <= BSW_NORMAL;
         dlyCnt <= '0;
         pending <= REQ_NONE;
      end else begin
         state <= next_state;
         if (next_state == BSW_DELAY && state != BSW_DELAY) begin
            pending <= modeReq;
            dlyCnt <= dlySel ? DLY_LONG_CYC : DLY_SHORT_CYC;
         end else if (next_state == BSW_SRST && state != BSW_SRST) begin
            dlyCnt <= RST_PULSE_CYC;
         end else if (!dlyDone) begin
            dlyCnt <= dlyCnt - CNT_W'(1);
         end
      end
   end

   // wake from ship or shutdown, and the self-clearing reset bit
   assign regDefault = ((state == BSW_SHIP || state == BSW_SHUT)
      && next_state == BSW_NORMAL) || (wrStb && address == OFF_CTRL
      && byteenable[0] && writedata[REGRST_BIT]);

   // power outputs straight from flops
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         batterySwitch <= 1'b1;
         serialEnable <= 1'b1;
         wakePullUp <= 1'b1;
         converterHiz <= 1'b0;
         chargerOff <= 1'b0;
      end else begin
         batterySwitch <= !(next_state == BSW_SHIP || next_state == BSW_SHUT
            || next_state == BSW_SRST || (next_state == BSW_SHIP_WAIT
            && permit));
         serialEnable <= !(next_state == BSW_SHIP
            || next_state == BSW_SHUT);
         wakePullUp <= next_state != BSW_SHUT;
         chargerOff <= next_state == BSW_SHUT;
         converterHiz <= hizReg || (next_state == BSW_SRST && adp);
      end
   end

   // ----------------------------------------------------------------
   // watchdog, default mode and interrupt pulse
   // ----------------------------------------------------------------
   logic [CNT_W-1:0] wdCnt;
   logic [CNT_W-1:0] wdLimit;
   logic [CNT_W-1:0] irqCnt;
   logic hostWrite;

   assign hostWrite = wrStb && !(address == OFF_CTRL && byteenable[0]
      && writedata[REGRST_BIT]);
   // period codes 01, 10, 11 give 50, 100, 200 watchdog units
   always_comb begin
      case (wdPeriod)
         2'b01: wdLimit = CNT_W'(50) * WD_UNIT_CYC;
         2'b10: wdLimit = CNT_W'(100) * WD_UNIT_CYC;
         default: wdLimit = CNT_W'(200) * WD_UNIT_CYC;
      endcase
   end
   assign wdExpire = hostMode && wdPeriod != 2'b00 && wdCnt >= wdLimit;

   // host/default mode and watchdog counter
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         hostMode <= 1'b0;
         wdCnt <= '0;
      end else if (wdExpire || regDefault) begin
         hostMode <= 1'b0;
         wdCnt <= '0;
      end else if (hostWrite) begin
         hostMode <= 1'b1;
         wdCnt <= '0;
      end else if (hostMode && !wdRestart) begin
         wdCnt <= wdCnt + CNT_W'(1);
      end
   end

   // status and flag: set on watchdog expiry, flag clears on read
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wdStatus <= 1'b1;
         wdFlag <= 1'b1;
      end else if (wdExpire) begin
         wdStatus <= 1'b1;
         wdFlag <= 1'b1;
      end else begin
         if (hostWrite) begin
            wdStatus <= 1'b0;
         end
         if (rdStb && address == OFF_STAT) begin
            wdFlag <= 1'b0;
         end
      end
   end

   // interrupt pulse; power-up pulse ignores the mask
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         irqCnt <= CNT_W'(IRQ_PULSE_CYC);
         irqN <= 1'b1;
      end else begin
         if (wdExpire && !wdMask) begin
            irqCnt <= CNT_W'(IRQ_PULSE_CYC);
         end else if (irqCnt != '0) begin
            irqCnt <= irqCnt - CNT_W'(1);
         end
         irqN <= (irqCnt == '0);
      end
   end

   // safety timers run only in default mode
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         safetyTimerShort <= 1'b1;
      end else begin
         safetyTimerShort <= !hostMode;
      end
   end

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   // outputs are registered from next_state, so they match state at once
   chk_ship_off: assert property (
      @(posedge clk) disable iff (!rst_n)
      state == BSW_SHIP |-> !batterySwitch && !serialEnable)
      else $error("switch or serial on in ship mode");
   chk_shut_pullup: assert property (
      @(posedge clk) disable iff (!rst_n)
      state == BSW_SHUT |-> !wakePullUp && chargerOff)
      else $error("pull-up on in shutdown");
   chk_shut_reject: assert property (
      @(posedge clk) disable iff (!rst_n)
      shutReject |=> modeReq == REQ_NONE || $past(wrStb))
      else $error("shutdown request kept with adapter");
   chk_cancel_req: assert property (
      @(posedge clk) disable iff (!rst_n)
      state == BSW_DELAY && modeReq == REQ_NONE |=> state == BSW_NORMAL)
      else $error("pending action not cancelled");
   chk_wd_expire: assert property (
      @(posedge clk) disable iff (!rst_n)
      wdExpire |=> !hostMode && wdStatus && wdFlag)
      else $error("watchdog expiry not handled");
   chk_host_write: assert property (
      @(posedge clk) disable iff (!rst_n)
      hostWrite && !wdExpire && !regDefault |=> hostMode && !wdStatus)
      else $error("write did not enter host mode");
   chk_irq_start: assert property (
      @(posedge clk) disable iff (!rst_n)
      wdExpire && !wdMask |=> ##1 !irqN)
      else $error("interrupt pulse missing");
   chk_srst_hiz: assert property (
      @(posedge clk) disable iff (!rst_n)
      next_state == BSW_SRST && adp |=> converterHiz && !batterySwitch)
      else $error("reset did not open switch with converter idle");
   chk_srst_clear: assert property (
      @(posedge clk) disable iff (!rst_n)
      state == BSW_SRST && next_state == BSW_NORMAL |=> modeReq == REQ_NONE)
      else $error("reset code kept after reset completed");
   chk_halve_charge_current_setting: assert property (
      @(posedge clk) disable iff (!rst_n)
      wdExpire && !regDefault |=>
      chargeCurrent == ($past(chargeCurrent) >> 1))
      else $error("charge current not halved");
endmodule : bsw_switch_watchdog
`default_nettype wire

// ### tb/bsw_host_model.sv
// Purpose: host side register master for the switch block
// Assumes: one clock, slave answers through waitrequest
// Notes: request holds until waitrequest is seen low
`timescale 1ns/10ps
`default_nettype none
module bsw_host_model
   import bsw_pkg::*;
(
   input wire logic clk, // bus clock
   output logic [3:0] address, // byte address
   output logic read, // read request
   output logic write, // write request
   output logic [31:0] writedata, // write data
   output logic [3:0] byteenable, // lane enables
   input wire logic [31:0] readdata, // read data
   input wire logic waitrequest // slave stall
);
   // idle bus at time zero
   initial begin
      address = 4'h0;
      read = 1'b0;
      write = 1'b0;
      writedata = 32'h0000_0000;
      byteenable = 4'hf;
   end
   // one write; an idle edge follows so strobes never toggle twice
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      address <= a;
      writedata <= {24'h00_0000, d};
      write <= 1'b1;
      do @(posedge clk); while (waitrequest !== 1'b0);
      write <= 1'b0;
      @(posedge clk);
   endtask : wr
   // one read; data taken at the edge that ends the wait
   task automatic rd(input logic [3:0] a, output logic [31:0] d);
      address <= a;
      read <= 1'b1;
      do @(posedge clk); while (waitrequest !== 1'b0);
      d = readdata;
      read <= 1'b0;
      @(posedge clk);
   endtask : rd
endmodule : bsw_host_model
`default_nettype wire

// ### tb/test_bsw_switch_watchdog.sv
// Purpose: self-checking bench for the switch / watchdog block
// Assumes: shortened delays through the design parameters
// Notes: delay windows allow the two-flop syncs and bus latency
`timescale 1ns/10ps
`default_nettype none
module test_bsw_switch_watchdog;
   import bsw_pkg::*;
   localparam int DS = 10;
   localparam int DL = 20;
   typedef struct {logic [3:0] a; logic [31:0] e;} bsw_row_s;
   logic clk = 1'b0, rst_n = 1'b0, adp = 1'b0, btnN = 1'b1;
   logic [3:0] address, byteenable;
   logic read, write, waitrequest, batSw, serOn, pullUp, converter_high_impedance;
   logic hostMode, chgOff, irqN, safeTmr;
   logic [31:0] writedata, readdata, d;
   int miscompares = 0, cmpCount = 0, n;
   bsw_row_s rows[6] = '{'{OFF_CTRL, 32'h0}, '{OFF_WDOG, 32'h1},
      '{OFF_CHG, 32'h28}, '{4'h2, 32'h0}, '{OFF_STAT, 32'h3},
      '{OFF_STAT, 32'h1}};
   // 40 MHz clock
   always #12.5 clk = ~clk;
   bsw_host_model i_host (.clk(clk), .address(address), .read(read),
      .write(write), .writedata(writedata), .byteenable(byteenable),
      .readdata(readdata), .waitrequest(waitrequest));
   bsw_switch_watchdog #(.DLY_LONG_CYC(CNT_W'(DL)),
      .DLY_SHORT_CYC(CNT_W'(DS)), .RST_HOLD_CYC(CNT_W'(40)),
      .EXIT_HOLD_CYC(CNT_W'(30)), .RST_PULSE_CYC(CNT_W'(15)),
      .WD_UNIT_CYC(CNT_W'(5))) i_dut (.clk(clk), .rst_n(rst_n),
      .address(address), .read(read), .write(write),
      .writedata(writedata), .byteenable(byteenable),
      .readdata(readdata), .waitrequest(waitrequest),
      .adapterPresent(adp), .wakeButtonN(btnN), .batterySwitch(batSw),
      .serialEnable(serOn), .wakePullUp(pullUp), .converterHiz(converter_high_impedance),
      .hostMode(hostMode), .safetyTimerShort(safeTmr), .chargerOff(chgOff),
      .irqN(irqN));
   // ---------------------------------------------------------------
   // helpers
   // ---------------------------------------------------------------
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      cmpCount++;
      if (g !== e) begin
         miscompares++;
         $display("[ERR] %0t got %h exp %h", $time, g, e);
      end
   endtask : chk
   // cycles until the switch reaches level v, bounded
   task automatic sw_wait(input logic v);
      for (n = 0; n < 200 && batSw !== v; n++) @(posedge clk);
   endtask : sw_wait
   // length of the next interrupt pulse
   task automatic irq_len();
      for (n = 0; n < 20 && irqN !== 1'b0; n++) @(posedge clk);
      for (n = 0; n < 11000 && irqN === 1'b0; n++) @(posedge clk);
   endtask : irq_len
   task automatic report_and_stop();
      $display("compares %0d mismatches %0d", cmpCount, miscompares);
      if (miscompares == 0 && cmpCount > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask : report_and_stop
   // hang guard, well above the expected run length
   initial begin
      repeat (60000) @(posedge clk);
      miscompares++;
      report_and_stop();
   end
   // ---------------------------------------------------------------
   // main sequence
   // ---------------------------------------------------------------
   initial begin
      repeat (5) @(posedge clk);
      chk({batSw, serOn, hostMode, irqN, safeTmr}, 5'b11011);
      rst_n <= 1'b1;
      irq_len();
      chk(n, IRQ_PULSE_CYC);
      chk(hostMode, 1'b0);
      // register defaults, unmapped slot, flag read once
      foreach (rows[i]) begin
         i_host.rd(rows[i].a, d);
         chk(d, rows[i].e);
      end
      // host mode, restart keeps it, expiry halves current
      i_host.wr(OFF_CHG, 8'h30);
      chk(hostMode, 1'b1);
      repeat (150) @(posedge clk);
      i_host.wr(OFF_WDOG, 8'h05);
      repeat (150) @(posedge clk);
      chk(hostMode, 1'b1);
      chk(safeTmr, 1'b0);
      for (n = 0; n < 400 && hostMode !== 1'b0; n++) @(posedge clk);
      irq_len();
      chk(n, IRQ_PULSE_CYC);
      i_host.rd(OFF_CHG, d);
      chk(d, 32'h18);
      i_host.rd(OFF_STAT, d);
      chk(d, 32'h3);
      chk(safeTmr, 1'b1);
      // register reset bit
      i_host.wr(OFF_CHG, 8'h30);
      i_host.wr(OFF_CTRL, 8'h84);
      i_host.rd(OFF_CTRL, d);
      chk(d, 32'h0);
      i_host.rd(OFF_CHG, d);
      chk(d, 32'h28);
      // adapter present: shutdown and permit-0 reset refused
      adp <= 1'b1;
      i_host.wr(OFF_CTRL, 8'h01);
      i_host.rd(OFF_CTRL, d);
      chk(d[1:0], 2'b00);
      i_host.wr(OFF_CTRL, 8'h03);
      i_host.rd(OFF_CTRL, d);
      chk(d[1:0], 2'b00);
      // permit 0 ship waits for removal; code 00 cancels
      i_host.wr(OFF_CTRL, 8'h02);
      i_host.wr(OFF_CTRL, 8'h00);
      adp <= 1'b0;
      repeat (3 * DS) @(posedge clk);
      chk(batSw, 1'b1);
      adp <= 1'b1;
      i_host.wr(OFF_CTRL, 8'h02);
      repeat (3 * DS) @(posedge clk);
      chk(batSw, 1'b1);
      adp <= 1'b0;
      sw_wait(1'b0);
      chk(serOn, 1'b0);
      adp <= 1'b1;
      sw_wait(1'b1);
      chk(batSw, 1'b1);
      // permit 1 ship opens with adapter, 00 closes again
      repeat (5) @(posedge clk);
      i_host.wr(OFF_CTRL, 8'h06);
      sw_wait(1'b0);
      chk(batSw, 1'b0);
      i_host.wr(OFF_CTRL, 8'h00);
      sw_wait(1'b1);
      chk(batSw, 1'b1);
      // permit 1 reset with adapter and accessory power on
      i_host.wr(OFF_CTRL, 8'h17);
      sw_wait(1'b0);
      chk({batSw, converter_high_impedance}, 2'b01);
      sw_wait(1'b1);
      chk({batSw, converter_high_impedance}, 2'b10);
      i_host.rd(OFF_CTRL, d);
      chk(d, 32'h0000_0004);
      repeat (3 * DS) @(posedge clk);
      chk(batSw, 1'b1);
      // ship on battery, long delay, button exit restores defaults
      adp <= 1'b0;
      i_host.wr(OFF_CHG, 8'h30);
      i_host.wr(OFF_CTRL, 8'h0a);
      sw_wait(1'b0);
      chk(n >= DL - 2 && n <= DL + 4, 1'b1);
      chk(serOn, 1'b0);
      btnN <= 1'b0;
      repeat (34) @(posedge clk);
      btnN <= 1'b1;
      sw_wait(1'b1);
      i_host.rd(OFF_CHG, d);
      chk(d, 32'h28);
      // shutdown on battery, short delay, button ignored
      i_host.wr(OFF_CTRL, 8'h11);
      sw_wait(1'b0);
      chk(n >= DS - 2 && n <= DS + 4, 1'b1);
      chk({serOn, pullUp, chgOff}, 3'b001);
      btnN <= 1'b0;
      repeat (50) @(posedge clk);
      btnN <= 1'b1;
      repeat (20) @(posedge clk);
      chk(batSw, 1'b0);
      adp <= 1'b1;
      sw_wait(1'b1);
      i_host.rd(OFF_CTRL, d);
      chk(d, 32'h0);
      report_and_stop();
   end
endmodule : test_bsw_switch_watchdog
`default_nettype wire
